// [cai_regs.svh]
// Constants of the CPU accumulator and index register block.
// Assumes it is included by bare name by the modules.
`ifndef CAI_REGS_SVH
`define CAI_REGS_SVH

// Widths and reset values
`define CAI_ACC_W 8
`define CAI_IDX_W 16
`define CAI_MAP_KBYTES 64
`define CAI_ACC_RST 8'h00
`define CAI_IDX_RST 16'h0000
`define CAI_CCR_RST 8'hd0

// Timing: cycles added by a second-index prefix
`define CAI_PREFIX_CYCLES 1

// Decimal adjust constants
`define CAI_BCD_DIGIT_MAX 4'h9
`define CAI_BCD_HI_LIMIT 4'h8
`define CAI_BCD_FIX_LO 8'h06
`define CAI_BCD_FIX_HI 8'h60

// Index step values
`define CAI_IDX_STEP_UP 16'h0001
`define CAI_IDX_STEP_DOWN 16'hffff
`define CAI_BYTE_ZERO 8'h00

`endif

// [cai_pkg.sv]
// Types shared by the accumulator and index register block.
// Assumes cai_regs.svh sits in the same folder.
package cai_pkg;

  // Operations the block executes
  typedef enum logic [4:0] {
    cai_op_nop,
    cai_op_load_acc_a,
    cai_op_load_acc_b,
    cai_op_load_acc_d,
    cai_op_load_first_index,
    cai_op_load_second_index,
    cai_op_add_mem_to_acc_a,
    cai_op_add_mem_to_acc_b,
    cai_op_sub_mem_from_acc_a,
    cai_op_sub_mem_from_acc_b,
    cai_op_add_acc_b_into_acc_a,
    cai_op_sub_acc_b_from_acc_a,
    cai_op_cmp_acc_a_with_acc_b,
    cai_op_decimal_adjust_acc_a,
    cai_op_move_acc_a_to_flags,
    cai_op_move_flags_to_acc_a,
    cai_op_add_acc_b_to_first_index,
    cai_op_add_acc_b_to_second_index,
    cai_op_inc_first_index,
    cai_op_dec_first_index,
    cai_op_inc_second_index,
    cai_op_dec_second_index,
    cai_op_addr_first_index,
    cai_op_addr_second_index
  } cai_op_e;

  // Condition code layout, bit 7 down to bit 0
  typedef struct packed {
    logic s;
    logic x;
    logic h;
    logic i;
    logic n;
    logic z;
    logic v;
    logic c;
  } cai_ccr_s;

  // One command from the sequencer
  typedef struct packed {
    cai_op_e op;
    logic [15:0] data;
    logic [7:0] offset;
    cai_ccr_s ccr;
  } cai_cmd_s;

  typedef enum logic {cai_st_idle, cai_st_prefix} cai_state_e;

endpackage : cai_pkg

// [cai_index_reg.sv]
// One 16-bit index register with load and wrapping add.
// Assumes the parent supplies a two's complement step for decrement.
`timescale 1ns/10ps
`include "cai_regs.svh"
module cai_index_reg import cai_pkg::*; #(
  parameter int IDX_W = `CAI_IDX_W
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Update controls
  input wire logic load_en_in,
  input wire logic [IDX_W-1:0] load_val_in,
  input wire logic add_en_in,
  input wire logic [IDX_W-1:0] add_val_in,
  // State
  output logic [IDX_W-1:0] value_out,
  output logic next_zero_out
);

  if (IDX_W != `CAI_IDX_W) begin : g_bad_width
    $error("cai_index_reg: index width must be 16");
  end

  // Carry out is dropped on purpose so the sum wraps
  logic [IDX_W-1:0] sum;
  assign sum = value_out + add_val_in;
  assign next_zero_out = (sum == '0);

  // Load wins over add; only one is ever asked per command
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      value_out <= `CAI_IDX_RST;
    end else if (load_en_in) begin
      value_out <= load_val_in;
    end else if (add_en_in) begin
      value_out <= sum;
    end
  end

endmodule : cai_index_reg

// [cai_core_regs.sv]
// Working registers of the CPU core: two accumulators, two index registers.
// Assumes a sequencer that holds cmd_in stable while cmd_ready_out is low,
// and that keeps the flag register itself, writing back ccr_out on ccr_wr_out.
`timescale 1ns/10ps
`include "cai_regs.svh"
module cai_core_regs import cai_pkg::*; #(
  parameter int ACC_W = `CAI_ACC_W
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Command port
  input wire cai_cmd_s cmd_in,
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  // Register views
  output logic [ACC_W-1:0] acc_a_out,
  output logic [ACC_W-1:0] acc_b_out,
  output logic [2*ACC_W-1:0] acc_d_out,
  output logic [2*ACC_W-1:0] index_reg_first_out,
  output logic [2*ACC_W-1:0] index_reg_second_out,
  // Effective address
  output logic [2*ACC_W-1:0] ea_out,
  output logic ea_valid_out,
  // Flag write-back
  output cai_ccr_s ccr_out,
  output logic ccr_wr_out
);

  localparam int IDX_W = 2 * ACC_W;

  if (ACC_W != `CAI_ACC_W) begin : g_bad_width
    $error("cai_core_regs: accumulator width must be 8");
  end

  cai_state_e st;
  cai_state_e next_st;
  logic [ACC_W-1:0] acc_a;
  logic [ACC_W-1:0] acc_b;
  logic [IDX_W-1:0] idx [2];
  logic [1:0] idx_next_zero;

  // Operation decode
  cai_op_e op;
  assign op = cmd_in.op;
  wire ld_a = (op == cai_op_load_acc_a);
  wire ld_b = (op == cai_op_load_acc_b);
  wire ld_d = (op == cai_op_load_acc_d);
  wire ld_x = (op == cai_op_load_first_index);
  wire ld_y = (op == cai_op_load_second_index);
  wire add_a = (op == cai_op_add_mem_to_acc_a);
  wire add_b = (op == cai_op_add_mem_to_acc_b);
  wire sub_a = (op == cai_op_sub_mem_from_acc_a);
  wire sub_b = (op == cai_op_sub_mem_from_acc_b);
  wire ab_add = (op == cai_op_add_acc_b_into_acc_a);
  wire ab_sub = (op == cai_op_sub_acc_b_from_acc_a);
  wire ab_cmp = (op == cai_op_cmp_acc_a_with_acc_b);
  wire dec_adj = (op == cai_op_decimal_adjust_acc_a);
  wire a_to_ccr = (op == cai_op_move_acc_a_to_flags);
  wire ccr_to_a = (op == cai_op_move_flags_to_acc_a);
  wire bx_add = (op == cai_op_add_acc_b_to_first_index);
  wire by_add = (op == cai_op_add_acc_b_to_second_index);
  wire x_inc = (op == cai_op_inc_first_index);
  wire x_dec = (op == cai_op_dec_first_index);
  wire y_inc = (op == cai_op_inc_second_index);
  wire y_dec = (op == cai_op_dec_second_index);
  wire x_ea = (op == cai_op_addr_first_index);
  wire y_ea = (op == cai_op_addr_second_index);

  // Groups of operations
  wire uses_y = ld_y | by_add | y_inc | y_dec | y_ea;
  wire is_sub = sub_a | sub_b | ab_sub | ab_cmp;
  wire src_b = ab_add | ab_sub | ab_cmp;
  wire dst_b = add_b | sub_b;
  wire alu_op = add_a | add_b | sub_a | sub_b | ab_add | ab_sub | ab_cmp;
  wire half_op = add_a | add_b | ab_add;
  wire step_op = x_inc | x_dec | y_inc | y_dec;

  // Second-index commands wait one prefix cycle before they execute
  assign cmd_ready_out = !(cmd_valid_in && uses_y && st == cai_st_idle);
  wire exec = cmd_valid_in & cmd_ready_out;

  always_comb begin
    next_st = st;
    case (st)
      cai_st_idle: begin
        if (cmd_valid_in && uses_y) begin
          next_st = cai_st_prefix;
        end
      end
      cai_st_prefix: begin
        next_st = cai_st_idle;
      end
      default: begin
        next_st = cai_st_idle;
      end
    endcase
  end

  // Binary arithmetic; second accumulator is the source of the pair ops and the destination of its memory ops
  wire [ACC_W-1:0] alu_src = src_b ? acc_b : cmd_in.data[ACC_W-1:0];
  wire [ACC_W-1:0] alu_dst = dst_b ? acc_b : acc_a;
  wire [ACC_W:0] sum9 = {1'b0, alu_dst} + {1'b0, alu_src};
  wire [ACC_W:0] dif9 = {1'b0, alu_dst} - {1'b0, alu_src};
  wire [4:0] sum_lo = {1'b0, alu_dst[3:0]} + {1'b0, alu_src[3:0]};
  wire [ACC_W-1:0] alu_res = is_sub ? dif9[ACC_W-1:0] : sum9[ACC_W-1:0];
  wire alu_c = is_sub ? dif9[ACC_W] : sum9[ACC_W];
  wire d7 = alu_dst[ACC_W-1];
  wire s7 = alu_src[ACC_W-1];
  wire r7 = alu_res[ACC_W-1];
  wire alu_v = is_sub ? ((d7 & ~s7 & ~r7) | (~d7 & s7 & r7))
                      : ((d7 & s7 & ~r7) | (~d7 & ~s7 & r7));

  // Decimal adjust of the first accumulator only
  wire lo_fix = cmd_in.ccr.h | (acc_a[3:0] > `CAI_BCD_DIGIT_MAX);
  wire hi_fix = cmd_in.ccr.c | (acc_a[7:4] > `CAI_BCD_DIGIT_MAX) |
                ((acc_a[7:4] > `CAI_BCD_HI_LIMIT) & (acc_a[3:0] > `CAI_BCD_DIGIT_MAX));
  wire [ACC_W-1:0] bcd_fix = (hi_fix ? `CAI_BCD_FIX_HI : `CAI_BYTE_ZERO) |
                             (lo_fix ? `CAI_BCD_FIX_LO : `CAI_BYTE_ZERO);
  wire [ACC_W:0] bcd9 = {1'b0, acc_a} + {1'b0, bcd_fix};

  // Next accumulator values
  wire wr_a = ld_a | ld_d | add_a | sub_a | ab_add | ab_sub | dec_adj | ccr_to_a;
  wire wr_b = ld_b | ld_d | add_b | sub_b;
  wire [ACC_W-1:0] next_acc_a = ld_d ? cmd_in.data[IDX_W-1:ACC_W] :
                                ccr_to_a ? ACC_W'(cmd_in.ccr) :
                                dec_adj ? bcd9[ACC_W-1:0] :
                                ld_a ? cmd_in.data[ACC_W-1:0] : alu_res;
  wire [ACC_W-1:0] next_acc_b = (ld_d | ld_b) ? cmd_in.data[ACC_W-1:0] : alu_res;

  // Accumulators; the double accumulator is never stored twice
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      acc_a <= `CAI_ACC_RST;
      acc_b <= `CAI_ACC_RST;
      st <= cai_st_idle;
    end else begin
      st <= next_st;
      if (exec && wr_a) begin
        acc_a <= next_acc_a;
      end
      if (exec && wr_b) begin
        acc_b <= next_acc_b;
      end
    end
  end

  assign acc_a_out = acc_a;
  assign acc_b_out = acc_b;
  assign acc_d_out = {acc_a, acc_b};

  // Index registers; the step is shared, the register select is per entry
  wire [IDX_W-1:0] idx_step = (bx_add | by_add) ? {`CAI_BYTE_ZERO, acc_b} :
                              (x_inc | y_inc) ? `CAI_IDX_STEP_UP : `CAI_IDX_STEP_DOWN;
  wire [1:0] idx_load = {ld_y, ld_x};
  wire [1:0] idx_add = {by_add | y_inc | y_dec, bx_add | x_inc | x_dec};

  for (genvar g = 0; g < 2; g++) begin : g_index
    cai_index_reg #(
      .IDX_W(IDX_W)
    ) u_index (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .load_en_in(exec & idx_load[g]),
      .load_val_in(cmd_in.data),
      .add_en_in(exec & idx_add[g]),
      .add_val_in(idx_step),
      .value_out(idx[g]),
      .next_zero_out(idx_next_zero[g])
    );
  end

  assign index_reg_first_out = idx[0];
  assign index_reg_second_out = idx[1];

  // Indexed address: zero-extended offset, carry out dropped to wrap
  wire [IDX_W-1:0] ea_base = y_ea ? idx[1] : idx[0];
  wire [IDX_W-1:0] ea_sum = ea_base + {`CAI_BYTE_ZERO, cmd_in.offset};

  // Flag results; untouched flags pass through from the sequencer
  cai_ccr_s next_ccr;
  always_comb begin
    next_ccr = cmd_in.ccr;
    if (alu_op) begin
      next_ccr.n = r7;
      next_ccr.z = (alu_res == '0);
      next_ccr.v = alu_v;
      next_ccr.c = alu_c;
      if (half_op) begin
        next_ccr.h = sum_lo[4];
      end
    end else if (dec_adj) begin
      next_ccr.n = bcd9[ACC_W-1];
      next_ccr.z = (bcd9[ACC_W-1:0] == '0);
      next_ccr.c = hi_fix | bcd9[ACC_W];
    end else if (ld_a | ld_b) begin
      next_ccr.n = cmd_in.data[ACC_W-1];
      next_ccr.z = (cmd_in.data[ACC_W-1:0] == '0);
      next_ccr.v = 1'b0;
    end else if (ld_d | ld_x | ld_y) begin
      next_ccr.n = cmd_in.data[IDX_W-1];
      next_ccr.z = (cmd_in.data == '0);
      next_ccr.v = 1'b0;
    end else if (step_op) begin
      // Only zero is reported for counting steps
      next_ccr.z = (x_inc | x_dec) ? idx_next_zero[0] : idx_next_zero[1];
    end else if (a_to_ccr) begin
      // Software may clear the X mask this way but never set it
      next_ccr = cai_ccr_s'(acc_a);
      next_ccr.x = cmd_in.ccr.x & acc_a[6];
    end
  end

  // Outputs stand one cycle after execution, whatever the operand's address
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ea_out <= `CAI_IDX_RST;
      ea_valid_out <= 1'b0;
      ccr_out <= cai_ccr_s'(`CAI_CCR_RST);
      ccr_wr_out <= 1'b0;
    end else begin
      ea_valid_out <= exec & (x_ea | y_ea);
      ccr_wr_out <= exec & (op != cai_op_nop);
      if (exec && (x_ea || y_ea)) begin
        ea_out <= ea_sum;
      end
      if (exec) begin
        ccr_out <= next_ccr;
      end
    end
  end

  // The block has no bus port, so none of its registers appear in the map

endmodule : cai_core_regs

// [cai_core_regs_chk.sv]
// Checker of the accumulator and index register block.
// Assumes it is bound to cai_core_regs and sees only its ports.
`timescale 1ns/10ps
module cai_core_regs_chk import cai_pkg::*; #(
  parameter int ACC_W = 8
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Command port
  input wire cai_cmd_s cmd_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_ready_out,
  // Register views and results
  input wire logic [ACC_W-1:0] acc_a_out,
  input wire logic [ACC_W-1:0] acc_b_out,
  input wire logic [2*ACC_W-1:0] acc_d_out,
  input wire logic [2*ACC_W-1:0] index_reg_first_out,
  input wire logic [2*ACC_W-1:0] index_reg_second_out,
  input wire logic [2*ACC_W-1:0] ea_out,
  input wire logic ea_valid_out,
  input wire cai_ccr_s ccr_out,
  input wire logic ccr_wr_out
);
  // Decode of the command taken at this edge
  wire logic take = cmd_valid_in && cmd_ready_out;
  wire cai_op_e op = cmd_in.op;
  wire logic [2*ACC_W-1:0] off = {{ACC_W{1'b0}}, cmd_in.offset};
  wire logic [2*ACC_W-1:0] b_ext = {{ACC_W{1'b0}}, acc_b_out};
  wire logic y_op = op inside {cai_op_load_second_index, cai_op_add_acc_b_to_second_index,
    cai_op_inc_second_index, cai_op_dec_second_index, cai_op_addr_second_index};

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  d_pair_a: assert property (acc_d_out == {acc_a_out, acc_b_out})
    else $error("double accumulator halves wrong");
  ea_first_a: assert property (take && op == cai_op_addr_first_index |=>
    ea_valid_out && ea_out == $past(index_reg_first_out) + $past(off))
    else $error("first index address wrong");
  ea_second_a: assert property (take && op == cai_op_addr_second_index |=>
    ea_valid_out && ea_out == $past(index_reg_second_out) + $past(off))
    else $error("second index address wrong");
  y_wait_a: assert property (take && y_op |-> $past(cmd_valid_in) && !$past(cmd_ready_out))
    else $error("second index op without extra cycle");
  aba_dir_a: assert property (take && op == cai_op_add_acc_b_into_acc_a |=>
    acc_a_out == $past(acc_a_out) + $past(acc_b_out) && $stable(acc_b_out))
    else $error("accumulator add direction wrong");
  abx_src_a: assert property (take && op == cai_op_add_acc_b_to_first_index |=>
    index_reg_first_out == $past(index_reg_first_out) + $past(b_ext) && $stable(acc_a_out))
    else $error("add to index source wrong");
  flags_a_a: assert property (take && op == cai_op_move_flags_to_acc_a |=>
    acc_a_out == $past(cmd_in.ccr) && $stable(acc_b_out))
    else $error("flag move target wrong");
  daa_keep_a: assert property (take && op == cai_op_decimal_adjust_acc_a |=>
    $stable(acc_b_out) && ccr_wr_out)
    else $error("decimal adjust touched second accumulator");
  // The X mask may only be cleared through this path, never set
  flags_load_a: assert property (take && op == cai_op_move_acc_a_to_flags |=>
    ccr_wr_out && ccr_out == {$past(acc_a_out[7]), $past(cmd_in.ccr.x) & $past(acc_a_out[6]),
    $past(acc_a_out[5:0])})
    else $error("flag load from first accumulator wrong");
endmodule : cai_core_regs_chk

bind cai_core_regs cai_core_regs_chk #(.ACC_W(ACC_W)) chk_i (
  .clk_sys_in(clk_sys_in),
  .rst_in(rst_in),
  .cmd_in(cmd_in),
  .cmd_valid_in(cmd_valid_in),
  .cmd_ready_out(cmd_ready_out),
  .acc_a_out(acc_a_out),
  .acc_b_out(acc_b_out),
  .acc_d_out(acc_d_out),
  .index_reg_first_out(index_reg_first_out),
  .index_reg_second_out(index_reg_second_out),
  .ea_out(ea_out),
  .ea_valid_out(ea_valid_out),
  .ccr_out(ccr_out),
  .ccr_wr_out(ccr_wr_out)
);

// [cai_mem_model.sv]
// Flat memory model answering each effective address of the core.
// Assumes address and strobe come from the block's registered outputs.
`timescale 1ns/10ps
module cai_mem_model (
  // Clock
  input wire logic clk_sys_in,
  // Address from the core
  input wire logic [15:0] addr_in,
  input wire logic rd_en_in,
  // Read data
  output logic [7:0] data_out
);
  // Every address answers alike one cycle later; between reads the bus inverts the last byte every cycle
  always_ff @(posedge clk_sys_in) begin
    if (rd_en_in) begin
      data_out <= addr_in[15:8] ^ addr_in[7:0] ^ 8'h5a;
    end else begin
      data_out <= ~data_out;
    end
  end
endmodule : cai_mem_model

// [cai_core_regs_tb.sv]
// Self-checking bench of the accumulator and index register block.
// Assumes the core, its checker and the memory model are compiled first.
`timescale 1ns/10ps
module cai_core_regs_tb import cai_pkg::*; ;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  cai_cmd_s cmd_in = '0;
  logic cmd_valid_in = 1'b0;
  wire logic cmd_ready_out, ea_valid_out, ccr_wr_out;
  wire logic [7:0] acc_a_out, acc_b_out, mem_data;
  wire logic [15:0] acc_d_out, index_reg_first_out, index_reg_second_out, ea_out;
  wire cai_ccr_s ccr_out;
  int err_total = 0;
  int tests_run = 0;
  logic [7:0] a = 8'h00, b = 8'h00;
  logic [15:0] x = 16'h0000, y = 16'h0000, ea = 16'h0000, r = 16'h0017;
  logic [63:0] exp_q[$];

  cai_core_regs uut (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .cmd_in(cmd_in),
    .cmd_valid_in(cmd_valid_in),
    .cmd_ready_out(cmd_ready_out),
    .acc_a_out(acc_a_out),
    .acc_b_out(acc_b_out),
    .acc_d_out(acc_d_out),
    .index_reg_first_out(index_reg_first_out),
    .index_reg_second_out(index_reg_second_out),
    .ea_out(ea_out),
    .ea_valid_out(ea_valid_out),
    .ccr_out(ccr_out),
    .ccr_wr_out(ccr_wr_out)
  );
  cai_mem_model mem (.clk_sys_in(clk_sys_in), .addr_in(ea_out), .rd_en_in(ea_valid_out),
    .data_out(mem_data));

  initial begin
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic check(input logic [63:0] got, input logic [63:0] want);
    tests_run++;
    if (got !== want) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask : check

  task automatic end_of_test();
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // Note the expected registers, then present the command until it is taken
  task automatic do_op(input cai_op_e op, input logic [15:0] d, input logic [7:0] off);
    int n;
    logic yop;
    n = 0;
    // Second-index commands must be refused exactly once before they are taken
    yop = op inside {cai_op_load_second_index, cai_op_add_acc_b_to_second_index,
      cai_op_inc_second_index, cai_op_dec_second_index, cai_op_addr_second_index};
    case (op)
      cai_op_load_acc_a: a = d[7:0];
      cai_op_load_acc_b: b = d[7:0];
      cai_op_load_acc_d: {a, b} = d;
      cai_op_load_first_index: x = d;
      cai_op_load_second_index: y = d;
      cai_op_add_mem_to_acc_a: a = a + d[7:0];
      cai_op_add_mem_to_acc_b: b = b + d[7:0];
      cai_op_sub_mem_from_acc_a: a = a - d[7:0];
      cai_op_sub_mem_from_acc_b: b = b - d[7:0];
      cai_op_add_acc_b_into_acc_a: a = a + b;
      cai_op_sub_acc_b_from_acc_a: a = a - b;
      cai_op_move_flags_to_acc_a: a = d[7:0];
      cai_op_add_acc_b_to_first_index: x = x + {8'h00, b};
      cai_op_add_acc_b_to_second_index: y = y + {8'h00, b};
      cai_op_inc_first_index: x = x + 16'h0001;
      cai_op_dec_first_index: x = x - 16'h0001;
      cai_op_inc_second_index: y = y + 16'h0001;
      cai_op_dec_second_index: y = y - 16'h0001;
      cai_op_addr_first_index: ea = x + {8'h00, off};
      cai_op_addr_second_index: ea = y + {8'h00, off};
      // The caller puts the expected decimal result in the upper data byte
      cai_op_decimal_adjust_acc_a: a = d[15:8];
      default: ; // Compare and the move to flags keep registers
    endcase
    if (op != cai_op_nop) exp_q.push_back({a, b, x, y, ea});
    cmd_in = '{op: op, data: d, offset: off, ccr: cai_ccr_s'(d[7:0])};
    cmd_valid_in = 1'b1;
    #2;
    while (cmd_ready_out !== 1'b1 && n < 4) begin
      @(posedge clk_sys_in);
      #3;
      n++;
    end
    check({63'h0, cmd_ready_out}, 64'h1);
    check(64'(n), {63'h0, yop});
    @(posedge clk_sys_in);
    #1;
  endtask : do_op

  // Each flag write-back marks a finished command; compare against the oldest note
  always @(negedge clk_sys_in) begin
    if (ccr_wr_out === 1'b1) begin
      check({acc_d_out, index_reg_first_out, index_reg_second_out, ea_out}, exp_q.pop_front());
    end
  end

  initial begin
    cai_op_e op;
    repeat (10) @(posedge clk_sys_in);
    #1 rst_in = 1'b0;
    check({acc_d_out, index_reg_first_out, index_reg_second_out, ea_out}, 64'h0);
    check({56'h0, ccr_out}, 64'hd0);
    do_op(cai_op_load_first_index, 16'hff80, 8'h00);
    do_op(cai_op_addr_first_index, 16'h0000, 8'hff);
    cmd_valid_in = 1'b0;
    @(posedge clk_sys_in);
    #1;
    check({56'h0, mem_data}, 64'h25);
    do_op(cai_op_load_first_index, 16'hffff, 8'h00);
    do_op(cai_op_inc_first_index, 16'h0000, 8'h00);
    do_op(cai_op_load_acc_d, 16'h1508, 8'h00);
    do_op(cai_op_add_mem_to_acc_a, 16'h0007, 8'h00);
    // Decimal 15 plus 7 gives 1c in binary; the adjust must turn it into 22
    do_op(cai_op_decimal_adjust_acc_a, 16'h2200, 8'h00);
    do_op(cai_op_load_second_index, 16'hfffe, 8'h00);
    do_op(cai_op_add_acc_b_to_second_index, 16'h0000, 8'h00);
    do_op(cai_op_addr_second_index, 16'h0000, 8'h80);
    // Random back-to-back traffic; decimal adjust is swapped for nop, so random bytes are never adjusted
    repeat (300) begin
      r = lfsr(r);
      op = cai_op_e'(r[4:0] % 5'h18);
      if (op == cai_op_decimal_adjust_acc_a) op = cai_op_nop;
      do_op(op, lfsr(r), r[15:8]);
    end
    cmd_valid_in = 1'b0;
    repeat (3) @(posedge clk_sys_in);
    check(64'(exp_q.size()), 64'h0);
    end_of_test();
  end

  // Far beyond 300 commands of at most two cycles each
  initial begin
    #40000;
    err_total++;
    end_of_test();
  end
endmodule : cai_core_regs_tb
